// file: hdl/ppn_pkg.sv
// ppn_pkg: constants for the parallel protocol negotiation block
// assumes a single 100 MHz clock and an APB register port
package ppn_pkg;
    // message header bytes of the protocol request
    localparam logic [7:0] EXT_MSG_BYTE = 8'h01;
    localparam logic [7:0] EXT_LEN_BYTE = 8'h06;
    localparam logic [7:0] PPR_CODE     = 8'h04;
    // field values with a fixed meaning
    localparam logic [7:0] PERIOD_ASYNC9 = 8'h09;
    localparam logic [7:0] OFFSET_ASYNC  = 8'h00;
    localparam logic [7:0] OFFSET_UNLIM  = 8'hFF;
    localparam logic [7:0] WIDTH_8       = 8'h00;
    localparam logic [7:0] WIDTH_16      = 8'h01;
    // option bits: bit0 iu, bit1 dt, bit2 qas
    localparam logic [2:0] OPT_ST   = 3'h0;
    localparam logic [2:0] OPT_DT   = 3'h2;
    localparam logic [2:0] OPT_IU   = 3'h3;
    localparam logic [2:0] OPT_QAS  = 3'h7;
    localparam int         OPT_IU_BIT = 0;
    // agreement record layout: period, offset, wide, options
    localparam int AGR_W = 20;
    localparam logic [AGR_W-1:0] AGR_RESET = 20'h00000;
    // register byte addresses
    localparam logic [7:0] REG_CAP    = 8'h00;
    localparam logic [7:0] REG_CTRL   = 8'h04;
    localparam logic [7:0] REG_START  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    // reset values of the registers
    localparam logic [19:0] CAP_RESET   = 20'hFFF0C;
    localparam logic [7:0]  CTRL_RESET  = 8'h30;
    // data-path modes decoded from the options
    typedef enum logic [1:0] {PPN_MODE_ST, PPN_MODE_DT_CRC, PPN_MODE_DT_IU, PPN_MODE_DT_IU_QAS} ppn_mode_t;
endpackage : ppn_pkg

// file: hdl/ppn_negotiator.sv
// ppn_negotiator: tracks transfer agreements per peer and drives the protocol request exchange
// assumes a message-phase engine that decodes bytes and signals events as one-cycle pulses
// What this block does
// - reset, target reset, power cycle or transceiver change: all peers async, narrow, no options
// - a device with any option capability never rejects a received request
// - period and offset apply only to data phases; all else asynchronous
// - negotiated width applies only to data phases; all else eight bits
// - responder echoes values, raising period, lowering offset or width only as needed
// - senders stay within peer limits; slower or smaller offset is allowed
// - responder clears option bits until a supported legal combination remains
// - non-zero reply offset means synchronous, zero means asynchronous
// - non-zero reply width used by both; unsupported width is rejected by originator
// - options decode to ST, DT with CRC, DT with units, or units plus QAS
// - reply with options zero and period 9h means narrow asynchronous
// - reject, parity error, bus free or silence: narrow asynchronous, options zero
// - failure of the initial request keeps the previous agreement
// - abnormal end of target-originated exchange: narrow asynchronous ST
// - in target-originated exchange, agreement holds once target leaves message out
// - target unable to accept initiator answer rejects; both go narrow asynchronous
// - retries after parity errors; at the limit target forces bus free, async
// - initiator originates with attention; target answers with request or reject
// - abnormal end of initiator-originated exchange: narrow asynchronous ST
// - target reply holds only after good final byte without attention
// - request is extended message, length 06h, code 04h, then the fields
// - offset zero ignores period and options; FFh means unlimited offset
// - width 0 is 8-bit, 1 is 16-bit; options need 16-bit
// - a change of the units enable makes the target go to bus free
`timescale 1ns/100ps
module ppn_negotiator #(
    parameter int PEERS = 16,
    parameter int ID_W  = 4
) (
    // clock and reset
    input  wire logic            clk_sys_in,
    input  wire logic            reset_in,
    // apb slave
    input  wire logic            psel_in,
    input  wire logic            penable_in,
    input  wire logic            pwrite_in,
    input  wire logic [7:0]      paddr_in,
    input  wire logic [31:0]     pwdata_in,
    output logic                 pready_out,
    output logic [31:0]          prdata_out,
    output logic                 pslverr_out,
    // bus context
    input  wire logic            role_target_in,
    input  wire logic [ID_W-1:0] peer_id_in,
    input  wire logic            data_phase_in,
    // received request and events from the message engine
    input  wire logic            rx_ppr_in,
    input  wire logic [7:0]      rx_len_in,
    input  wire logic [7:0]      rx_code_in,
    input  wire logic [7:0]      rx_period_in,
    input  wire logic [7:0]      rx_offset_in,
    input  wire logic [7:0]      rx_width_in,
    input  wire logic [2:0]      rx_opts_in,
    input  wire logic            rx_reject_in,
    input  wire logic            rx_par_err_in,
    input  wire logic            bus_free_unexp_in,
    input  wire logic            tx_fail_in,
    input  wire logic            accept_in,
    input  wire logic            no_resp_in,
    input  wire logic            hard_reset_in,
    input  wire logic            target_reset_in,
    input  wire logic            xcvr_change_in,
    // request and actions towards the message engine
    output logic                 tx_ppr_out,
    output logic [7:0]           tx_period_out,
    output logic [7:0]           tx_offset_out,
    output logic [7:0]           tx_width_out,
    output logic [2:0]           tx_opts_out,
    output logic                 tx_reject_out,
    output logic                 atn_out,
    output logic                 bus_free_out,
    // agreement in force for the current peer
    output logic                 use_sync_out,
    output logic                 use_wide_out,
    output logic [7:0]           agr_period_out,
    output logic [7:0]           agr_offset_out,
    output ppn_pkg::ppn_mode_t   agr_mode_out
);
    typedef enum {ST_IDLE, ST_WAIT_REPLY, ST_WAIT_ACCEPT} ppn_state_t;

    // legal option combination at or below the asked one
    function automatic logic [2:0] legal_opts(input logic [2:0] o);
        if (o == ppn_pkg::OPT_QAS) legal_opts = ppn_pkg::OPT_QAS;
        else if (o[1:0] == 2'h3) legal_opts = ppn_pkg::OPT_IU;
        else if (o[1]) legal_opts = ppn_pkg::OPT_DT;
        else legal_opts = ppn_pkg::OPT_ST;
    endfunction : legal_opts

    // packs fields into an agreement, applying the async corner cases
    function automatic logic [19:0] norm_agr(input logic [7:0] p, input logic [7:0] off,
                                             input logic w, input logic [2:0] o);
        logic [2:0] oo;
        oo = legal_opts(o);
        if (!w) oo = ppn_pkg::OPT_ST;
        if (off == ppn_pkg::OFFSET_ASYNC) norm_agr = {8'h00, 8'h00, w, 3'h0};
        else if (oo == ppn_pkg::OPT_ST && p == ppn_pkg::PERIOD_ASYNC9)
            norm_agr = ppn_pkg::AGR_RESET;
        else norm_agr = {p, off, w, oo};                           // ffh stays unlimited
    endfunction : norm_agr

    // decode of the option field into a data-phase mode
    function automatic ppn_pkg::ppn_mode_t mode_of(input logic [2:0] o);
        case (o)
            ppn_pkg::OPT_DT:  mode_of = ppn_pkg::PPN_MODE_DT_CRC;
            ppn_pkg::OPT_IU:  mode_of = ppn_pkg::PPN_MODE_DT_IU;
            ppn_pkg::OPT_QAS: mode_of = ppn_pkg::PPN_MODE_DT_IU_QAS;
            default:          mode_of = ppn_pkg::PPN_MODE_ST;
        endcase
    endfunction : mode_of

    logic [ppn_pkg::AGR_W-1:0] agr_mem [PEERS];
    logic [19:0]               cap_r;
    logic [7:0]                ctrl_r;
    logic                      start_r;
    logic [ID_W-1:0]           start_peer_r;
    ppn_state_t                state_r;
    logic [ID_W-1:0]           pend_peer_r;
    logic [19:0]               pend_agr_r;
    logic [3:0]                retry_r;
    logic                      we_r;
    logic [19:0]               resp_agr;
    logic [19:0]               cur_agr;
    logic                      rx_hdr_ok;
    logic                      wide_bad;
    logic                      fail_evt;
    logic                      reset_evt;
    logic                      retry_go;
    logic                      commit;
    logic                      fallback;
    logic                      apb_acc;

    // capability fields: min period, max offset, wide, options
    wire logic [7:0] cap_period = cap_r[7:0];
    wire logic [7:0] cap_offset = cap_r[15:8];
    wire logic       cap_wide   = cap_r[16];
    wire logic [2:0] cap_opts   = cap_r[19:17];

    assign apb_acc   = psel_in && penable_in && !pready_out;
    assign reset_evt = hard_reset_in || target_reset_in || xcvr_change_in;
    assign rx_hdr_ok = rx_ppr_in && rx_len_in == ppn_pkg::EXT_LEN_BYTE
                       && rx_code_in == ppn_pkg::PPR_CODE;
    assign fail_evt  = rx_reject_in || rx_par_err_in || bus_free_unexp_in || no_resp_in;
    assign wide_bad  = rx_width_in > ppn_pkg::WIDTH_16
                       || (rx_width_in == ppn_pkg::WIDTH_16 && !cap_wide);
    assign retry_go  = role_target_in && rx_par_err_in && retry_r < ctrl_r[7:4];
    assign cur_agr   = agr_mem[peer_id_in];

    // responder values: slower, smaller, narrower only where needed
    always_comb begin
        logic [7:0] p;
        logic [7:0] o;
        p = (rx_period_in < cap_period) ? cap_period : rx_period_in;
        o = (rx_offset_in > cap_offset) ? cap_offset : rx_offset_in;
        resp_agr = norm_agr(p, o, rx_width_in == ppn_pkg::WIDTH_16 && cap_wide,
                            rx_opts_in & cap_opts);
    end

    // apb registers; pready comes one cycle into the access phase
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pready_out   <= 1'b0;
            pslverr_out  <= 1'b0;
            prdata_out   <= 32'h00000000;
            cap_r        <= ppn_pkg::CAP_RESET;
            ctrl_r       <= ppn_pkg::CTRL_RESET;
            start_r      <= 1'b0;
            start_peer_r <= '0;
        end else begin
            pready_out  <= apb_acc;
            pslverr_out <= 1'b0;
            start_r     <= 1'b0;
            prdata_out  <= 32'h00000000;
            if (apb_acc) begin
                case (paddr_in)
                    ppn_pkg::REG_CAP: begin
                        if (pwrite_in) cap_r <= pwdata_in[19:0];
                        prdata_out <= {12'h000, cap_r};
                    end
                    ppn_pkg::REG_CTRL: begin
                        if (pwrite_in) ctrl_r <= pwdata_in[7:0];
                        prdata_out <= {24'h000000, ctrl_r};
                    end
                    ppn_pkg::REG_START: begin
                        if (pwrite_in) begin
                            start_r      <= 1'b1;
                            start_peer_r <= pwdata_in[ID_W-1:0];
                        end
                    end
                    ppn_pkg::REG_STATUS: begin
                        prdata_out <= {6'h00, state_r == ST_IDLE ? 2'h0 : 2'h1, retry_r,
                                       agr_mem[ctrl_r[ID_W-1:0]]};
                    end
                    default: pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    // negotiation sequence; failure events act on the pending peer only, reset events clear all peers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_r       <= ST_IDLE;
            pend_peer_r   <= '0;
            pend_agr_r    <= ppn_pkg::AGR_RESET;
            retry_r       <= 4'h0;
            tx_ppr_out    <= 1'b0;
            tx_period_out <= 8'h00;
            tx_offset_out <= 8'h00;
            tx_width_out  <= 8'h00;
            tx_opts_out   <= 3'h0;
            tx_reject_out <= 1'b0;
            atn_out       <= 1'b0;
            commit        <= 1'b0;
            fallback      <= 1'b0;
        end else begin
            tx_ppr_out    <= 1'b0;
            tx_reject_out <= 1'b0;
            atn_out       <= 1'b0;
            commit        <= 1'b0;
            fallback      <= 1'b0;
            if (reset_evt) begin
                state_r <= ST_IDLE;
                retry_r <= 4'h0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        retry_r <= 4'h0;
                        if (rx_hdr_ok) begin
                            // never answered by a reject while any option is supported
                            tx_ppr_out    <= 1'b1;
                            tx_period_out <= resp_agr[19:12];
                            tx_offset_out <= resp_agr[11:4];
                            tx_width_out  <= {7'h00, resp_agr[3]};
                            tx_opts_out   <= resp_agr[2:0];
                            pend_peer_r   <= peer_id_in;
                            pend_agr_r    <= resp_agr;
                            state_r       <= ST_WAIT_ACCEPT;
                        end else if (start_r) begin
                            tx_ppr_out    <= 1'b1;
                            atn_out       <= !role_target_in;
                            tx_period_out <= cap_period;
                            tx_offset_out <= cap_offset;
                            tx_width_out  <= {7'h00, cap_wide};
                            tx_opts_out   <= cap_opts;
                            pend_peer_r   <= start_peer_r;
                            state_r       <= ST_WAIT_REPLY;
                        end
                    end
                    ST_WAIT_REPLY: begin
                        if (tx_fail_in) begin
                            state_r <= ST_IDLE;                      // keeps old agreement
                        end else if (rx_hdr_ok && wide_bad) begin
                            tx_reject_out <= 1'b1;
                            atn_out       <= !role_target_in;
                            fallback      <= 1'b1;
                            state_r       <= ST_IDLE;
                        end else if (rx_hdr_ok) begin
                            pend_agr_r <= norm_agr(rx_period_in, rx_offset_in,
                                                   rx_width_in == ppn_pkg::WIDTH_16, rx_opts_in);
                            commit     <= 1'b1;                      // good last byte, no attention
                            state_r    <= ST_IDLE;
                        end else if (fail_evt) begin
                            fallback <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                    ST_WAIT_ACCEPT: begin
                        if (accept_in) begin
                            commit  <= 1'b1;                         // leaves message out
                            state_r <= ST_IDLE;
                        end else if (retry_go) begin
                            retry_r    <= retry_r + 4'h1;            // resend the same answer
                            tx_ppr_out <= 1'b1;
                        end else if (fail_evt || tx_fail_in) begin
                            fallback <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // target ends with an unexpected bus free at the retry limit or when a commit changes the units enable
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            bus_free_out <= 1'b0;
            we_r         <= 1'b0;
        end else begin
            we_r         <= commit;
            bus_free_out <= (state_r == ST_WAIT_ACCEPT && role_target_in && rx_par_err_in && !retry_go
                             && !reset_evt && !accept_in)
                            || (commit && role_target_in
                                && pend_agr_r[ppn_pkg::OPT_IU_BIT] != agr_mem[pend_peer_r][ppn_pkg::OPT_IU_BIT]);
        end
    end

    // agreement table, one record per peer
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || reset_evt) begin
            for (int i = 0; i < PEERS; i++) agr_mem[i] <= ppn_pkg::AGR_RESET;
        end else if (commit) begin
            agr_mem[pend_peer_r] <= pend_agr_r;
        end else if (fallback) begin
            agr_mem[pend_peer_r] <= ppn_pkg::AGR_RESET;
        end
    end

    // limits for the current peer; only data phases may go sync or wide
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            use_sync_out   <= 1'b0;
            use_wide_out   <= 1'b0;
            agr_period_out <= 8'h00;
            agr_offset_out <= 8'h00;
            agr_mode_out   <= ppn_pkg::PPN_MODE_ST;
        end else begin
            use_sync_out   <= data_phase_in && cur_agr[11:4] != ppn_pkg::OFFSET_ASYNC;
            use_wide_out   <= data_phase_in && cur_agr[3];
            agr_period_out <= cur_agr[19:12];                        // sender may go slower
            agr_offset_out <= cur_agr[11:4];
            agr_mode_out   <= mode_of(cur_agr[2:0]);
        end
    end

    // checks
    sequence s_reply_fail;
        state_r == ST_WAIT_REPLY && !tx_fail_in && !rx_hdr_ok && fail_evt && !reset_evt;
    endsequence
    sequence s_accept;
        state_r == ST_WAIT_ACCEPT && accept_in && !reset_evt;
    endsequence

    AST_RESET_ASYNC: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        reset_evt |=> ##1 agr_mem[peer_id_in] == ppn_pkg::AGR_RESET)
        else $error("agreement not cleared by reset event");
    AST_NO_REJECT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state_r == ST_IDLE && rx_hdr_ok && !reset_evt |=> tx_ppr_out && !tx_reject_out)
        else $error("received request not answered by a request");
    AST_SYNC_DATA: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !$past(data_phase_in) |-> !use_sync_out && !use_wide_out)
        else $error("sync or wide outside data phase");
    AST_RESP_LIMITS: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state_r == ST_IDLE && rx_hdr_ok && !reset_evt && rx_offset_in != 8'h00
        |=> tx_offset_out <= $past(rx_offset_in) && tx_opts_out == (tx_opts_out & $past(rx_opts_in)))
        else $error("response widened the request");
    AST_REPLY_FAIL: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_reply_fail |=> fallback ##1 agr_mem[pend_peer_r] == ppn_pkg::AGR_RESET)
        else $error("failed reply did not fall back");
    AST_KEEP_OLD: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state_r == ST_WAIT_REPLY && tx_fail_in && !reset_evt |=> !commit && !fallback && state_r == ST_IDLE)
        else $error("initial failure changed agreement");
    AST_ACCEPT_COMMIT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_accept |=> commit ##1 agr_mem[$past(pend_peer_r, 2)] == $past(pend_agr_r, 2))
        else $error("accepted agreement not stored");
    AST_WIDE_REJECT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        state_r == ST_WAIT_REPLY && rx_hdr_ok && wide_bad && !tx_fail_in && !reset_evt
        |=> tx_reject_out && fallback)
        else $error("unsupported width not rejected");
    AST_RETRY_LIMIT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        retry_r <= ctrl_r[7:4] || $past(ctrl_r[7:4]) != ctrl_r[7:4])
        else $error("retry count past limit");
endmodule : ppn_negotiator

// file: verif/ppn_peer_model.sv
// ppn_peer_model: peer message engine that sends requests and accepts our answers
// assumes the bench clock; header bytes are tied off by the bench
`timescale 1ns/100ps
module ppn_peer_model (
    // clock
    input  wire logic       clk_sys_in,
    // from the negotiator and the bench
    input  wire logic       tx_ppr_in,
    input  wire logic       accept_en_in,
    // towards the negotiator
    output logic            rx_ppr_out,
    output logic [7:0]      rx_period_out,
    output logic [7:0]      rx_offset_out,
    output logic [7:0]      rx_width_out,
    output logic [2:0]      rx_opts_out,
    output logic            accept_out
);
    initial {rx_ppr_out, rx_period_out, rx_offset_out, rx_width_out, rx_opts_out, accept_out} = '0;
    // accept an answer one cycle after it shows, only when the bench allows it
    always @(posedge clk_sys_in) begin
        accept_out <= tx_ppr_in & accept_en_in;
    end
    // one request, fields valid with the pulse only
    task automatic send(input logic [26:0] f);
        @(posedge clk_sys_in);
        rx_ppr_out <= 1'b1;
        {rx_period_out, rx_offset_out, rx_width_out, rx_opts_out} <= f;
        @(posedge clk_sys_in);
        rx_ppr_out <= 1'b0;
        // inverse, so stale fields are never mistaken for valid ones
        {rx_period_out, rx_offset_out, rx_width_out, rx_opts_out} <= ~f;
    endtask : send
endmodule : ppn_peer_model

// file: verif/test_ppr_transfer_negotiation.sv
// test_ppr_transfer_negotiation: self-checking bench for the negotiator
// assumes APB answers one cycle after the access phase is taken
`timescale 1ns/100ps
module test_ppr_transfer_negotiation;
    logic        clk_sys_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic        data_phase_in = 1'b0, accept_en = 1'b0, role_t = 1'b0, rde, pready_out, pslverr_out, rx_ppr_in;
    logic        accept_in;
    logic        tx_ppr_out, tx_reject_out, atn_out, bus_free_out, use_sync_out, use_wide_out;
    logic [7:0]  paddr_in = 8'h00, ev = 8'h00; // reject,parity,free,txfail,noresp,hard,target,xcvr
    logic [31:0] pwdata_in = 32'h0, prdata_out, rdq;
    logic [7:0]  rx_period_in, rx_offset_in, rx_width_in, tx_period_out, tx_offset_out, tx_width_out;
    logic [7:0]  agr_period_out, agr_offset_out;
    logic [2:0]  rx_opts_in, tx_opts_out;
    ppn_pkg::ppn_mode_t agr_mode_out;
    int          num_errors = 0, check_count = 0, cycles = 0;
    ppn_negotiator dut (.*, .role_target_in(role_t), .peer_id_in(4'h0), .rx_len_in(ppn_pkg::EXT_LEN_BYTE),
        .rx_code_in(ppn_pkg::PPR_CODE), .rx_reject_in(ev[7]), .rx_par_err_in(ev[6]), .bus_free_unexp_in(ev[5]),
        .tx_fail_in(ev[4]), .no_resp_in(ev[3]), .hard_reset_in(ev[2]), .target_reset_in(ev[1]),
        .xcvr_change_in(ev[0]));
    ppn_peer_model peer (.clk_sys_in, .tx_ppr_in(tx_ppr_out), .accept_en_in(accept_en), .rx_ppr_out(rx_ppr_in),
        .rx_period_out(rx_period_in), .rx_offset_out(rx_offset_in), .rx_width_out(rx_width_in),
        .rx_opts_out(rx_opts_in), .accept_out(accept_in));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    // hang guard: the whole run needs far fewer cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do @(posedge clk_sys_in); while (pready_out !== 1'b1);
        rdq = prdata_out;
        rde = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask : apb
    task automatic wait_tx();
        for (int n = 0; n < 10 && tx_ppr_out !== 1'b1; n++) @(posedge clk_sys_in);
        chk("tx request", 32'h1, {31'h0, tx_ppr_out});
    endtask : wait_tx
    // peer sends a request, our answer is compared, then the peer accepts
    task automatic resp(input logic [26:0] req, input logic [26:0] exp);
        accept_en <= 1'b1;
        peer.send(req);
        wait_tx();
        chk("tx fields", {5'h0, exp}, {5'h0, tx_period_out, tx_offset_out, tx_width_out, tx_opts_out});
        repeat (6) @(posedge clk_sys_in);
    endtask : resp
    task automatic t_regs();
        apb(1'b0, ppn_pkg::REG_CAP, 32'h0);
        chk("cap", {12'h0, ppn_pkg::CAP_RESET}, rdq);
        apb(1'b0, ppn_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h0, rdq);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rde});
        $display("regs done");
    endtask : t_regs
    task automatic t_answer();
        resp({8'h20, 8'h10, 8'h00, 3'h3}, {8'h20, 8'h10, 8'h00, 3'h0});
        resp({8'h20, 8'h10, 8'h01, 3'h1}, {8'h20, 8'h10, 8'h01, 3'h0});
        resp({8'h0C, 8'hFF, 8'h01, 3'h7}, {8'h0C, 8'hFF, 8'h01, 3'h7});
        resp({8'h0A, 8'h20, 8'h01, 3'h3}, {8'h0C, 8'h20, 8'h01, 3'h3});
        data_phase_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk("data use", 32'h000C20E, {12'h0, agr_period_out, agr_offset_out, use_sync_out, use_wide_out,
            agr_mode_out});
        data_phase_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk("other use", 32'h000C202, {12'h0, agr_period_out, agr_offset_out, use_sync_out, use_wide_out,
            agr_mode_out});
        $display("answer done");
    endtask : t_answer
    // originate after an agreement, then break the exchange with each event
    task automatic t_events();
        for (int i = 0; i < 8; i++) begin
            resp({8'h0A, 8'h20, 8'h01, 3'h3}, {8'h0C, 8'h20, 8'h01, 3'h3});
            accept_en <= 1'b0;
            apb(1'b1, ppn_pkg::REG_START, 32'h0);
            wait_tx();
            chk("atn", 32'h1, {31'h0, atn_out});
            @(posedge clk_sys_in);
            ev[i] <= 1'b1;
            @(posedge clk_sys_in);
            ev <= 8'h00;
            repeat (4) @(posedge clk_sys_in);
            apb(1'b0, ppn_pkg::REG_STATUS, 32'h0);
            chk("status event", (i == 4) ? 32'h0C20B : 32'h0, rdq);
        end
        $display("events done");
    endtask : t_events
    // target role: peer initiator answers, rejects our answer, sends a bad width, keeps failing parity
    task automatic t_target();
        role_t <= 1'b1;
        apb(1'b1, ppn_pkg::REG_START, 32'h0);
        wait_tx();
        chk("target atn", 32'h0, {31'h0, atn_out});
        peer.send({8'h0C, 8'h20, 8'h01, 3'h3});
        repeat (2) @(posedge clk_sys_in);
        chk("iu bus free", 32'h1, {31'h0, bus_free_out});
        apb(1'b0, ppn_pkg::REG_STATUS, 32'h0);
        chk("target agreement", 32'h0C20B, rdq);
        peer.send({8'h0C, 8'h20, 8'h01, 3'h3});
        wait_tx();
        ev[7] <= 1'b1;
        @(posedge clk_sys_in);
        ev <= 8'h00;
        apb(1'b0, ppn_pkg::REG_STATUS, 32'h0);
        chk("rejected answer", 32'h0, rdq);
        apb(1'b1, ppn_pkg::REG_START, 32'h0);
        wait_tx();
        peer.send({8'h0C, 8'h20, 8'h02, 3'h3});
        @(posedge clk_sys_in);
        chk("wide reject", 32'h1, {31'h0, tx_reject_out});
        peer.send({8'h0C, 8'h20, 8'h01, 3'h3});
        wait_tx();
        ev[6] <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        ev <= 8'h00;
        @(posedge clk_sys_in);
        chk("retry bus free", 32'h1, {31'h0, bus_free_out});
        $display("target done");
    endtask : t_target
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        t_regs();
        t_answer();
        t_events();
        t_target();
        conclude();
    end
endmodule : test_ppr_transfer_negotiation
